// ==== logic/t8wc_regs.svh ====
/*
  Register map, field positions and reset values of the 8-bit timer
  waveform and compare-output block. Assumes a 32-bit Wishbone slave with
  byte addresses; each register sits in the low byte of one word.
*/
`ifndef T8WC_REGS_SVH
`define T8WC_REGS_SVH

// ============================================================
// Offsets
`define T8WC_ADR_CTRLA 8'h24
`define T8WC_ADR_CTRLB 8'h28
`define T8WC_ADR_COUNT 8'h2C
`define T8WC_ADR_CMPA 8'h30
`define T8WC_ADR_CMPB 8'h34
`define T8WC_ADR_STAT 8'h38
`define T8WC_ADR_CLR 8'h3C
`define T8WC_ADR_IEN 8'h40
`define T8WC_ADR_DIR 8'h44

// ============================================================
// Fields
`define T8WC_COMA_HI 7
`define T8WC_COMA_LO 6
`define T8WC_COMB_HI 5
`define T8WC_COMB_LO 4
`define T8WC_CTRLA_MASK 8'hF3
`define T8WC_TOPBIT_POS 3
`define T8WC_FLAG_OVF 0
`define T8WC_FLAG_MA 1
`define T8WC_FLAG_MB 2
`define T8WC_DIR_A 0
`define T8WC_DIR_B 1

// ============================================================
// Values
`define T8WC_RST_BYTE 8'h00
`define T8WC_RST_FLAGS 3'h0
`define T8WC_MAX 8'hFF
`define T8WC_BOTTOM 8'h00

`endif

// ==== logic/t8wc_pkg.sv ====
/*
  Types of the 8-bit timer waveform and compare-output block.
  Assumes the constants of t8wc_regs.svh for all numbers.
*/
package t8wc_pkg;

  // ============================================================
  // Enumerations
  typedef enum logic [1:0] {
    T8WC_BUS_IDLE = 2'b01,
    T8WC_BUS_ACK = 2'b10
  } t8wc_bus_st_t;

  typedef enum logic [3:0] {
    T8WC_WAVE_NORMAL = 4'b0001,
    T8WC_WAVE_FAST = 4'b0010,
    T8WC_WAVE_PHASE = 4'b0100,
    T8WC_WAVE_HOLD = 4'b1000
  } t8wc_wave_t;

  // ============================================================
  // Carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } t8wc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } t8wc_wb_rsp_t;

  typedef struct packed {
    logic a_o;
    logic a_oe;
    logic b_o;
    logic b_oe;
  } t8wc_pins_t;

  typedef struct packed {
    logic match;
    logic up;
    logic at_bottom;
    logic at_top;
    logic special;
  } t8wc_chan_ev_t;

  typedef struct packed {
    t8wc_bus_st_t bus;
    logic [7:0] ctrl_a;
    logic top_bit;
    logic [7:0] cnt;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_b;
    logic down;
    logic blocked;
    logic oc_a;
    logic oc_b;
    logic [2:0] status;
    logic [2:0] ien;
    logic [1:0] dir;
    t8wc_wb_rsp_t rsp;
    t8wc_pins_t pins;
    logic irq;
  } t8wc_state_t;

endpackage : t8wc_pkg

// ==== logic/t8wc_chan.sv ====
/*
  One compare-output channel: next level of the compare output and
  whether it owns the pin. Purely combinational; the caller holds the
  output flip-flop and qualifies every event with the timer tick.
*/
`timescale 1ns/1ps

module t8wc_chan (
  input wire t8wc_pkg::t8wc_wave_t wave,
  input wire logic [1:0] com,
  input wire logic is_a,
  input wire logic top_bit,
  input wire t8wc_pkg::t8wc_chan_ev_t ev,
  input wire logic oc_cur,
  output logic oc_nxt,
  output logic connected
);

  // ============================================================
  // Output level
  always_comb begin
    oc_nxt = oc_cur;
    connected = |com;
    case (wave)
      t8wc_pkg::T8WC_WAVE_FAST, t8wc_pkg::T8WC_WAVE_PHASE: begin
        // Code 1 toggles only on channel A with the top mode bit set
        connected = com[1] | (com[0] & is_a & top_bit); // [RULE2]
        if (com == 2'b01) begin
          if (is_a && top_bit && ev.match) begin
            oc_nxt = !oc_cur; // [RULE6] [RULE7] [RULE9]
          end
        end else if (com[1] && wave == t8wc_pkg::T8WC_WAVE_FAST) begin
          if (ev.match && !ev.special) begin
            oc_nxt = com[0]; // [RULE5] [RULE7]
          end
          // Wrap action applied last, so it wins a match at TOP
          if (ev.at_bottom) begin
            oc_nxt = !com[0]; // [RULE5] [RULE10] [RULE12]
          end
        end else if (com[1]) begin
          if (ev.special) begin
            if (ev.at_top) begin
              oc_nxt = !com[0]; // [RULE11] [RULE12]
            end
          end else if (ev.match) begin
            oc_nxt = ev.up ? com[0] : !com[0]; // [RULE8] [RULE9]
          end
        end
      end
      t8wc_pkg::T8WC_WAVE_NORMAL: begin
        if (ev.match) begin
          case (com)
            2'b01: oc_nxt = !oc_cur; // [RULE3] [RULE4]
            2'b10: oc_nxt = 1'b0; // [RULE3] [RULE4]
            2'b11: oc_nxt = 1'b1; // [RULE3] [RULE4]
            default: oc_nxt = oc_cur;
          endcase
        end
      end
      default: oc_nxt = oc_cur;
    endcase
  end

endmodule : t8wc_chan

// ==== logic/t8wc_top.sv ====
/*
  8-bit timer/counter with two compare outputs, waveform modes,
  sticky event flags and one level interrupt, behind a classic
  Wishbone slave. Assumes a prescaler that supplies a one-cycle
  tick enable and port logic that supplies normal pin data.
*/
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "t8wc_regs.svh"

// Contract
// RULE1 - Counter runs on the system clock; tick only enables one step.
// RULE2 - Nonzero output-mode code lets compare output own pin; direction bit drives.
// RULE3 - Non-PWM channel A: 0 off, 1 toggle, 2 clear, 3 set on match.
// RULE4 - Non-PWM channel B: 0 off, 1 toggle, 2 clear, 3 set on match.
// RULE5 - Fast PWM: code 2 clear on match, set at BOTTOM; 3 reverse.
// RULE6 - PWM channel A code 1: off unless top mode bit, then toggle.
// RULE7 - Fast PWM channel B: code 1 reserved; 2 and 3 as PWM.
// RULE8 - Phase PWM channel A: code 2 clear up, set down; 3 reverse.
// RULE9 - Phase PWM channel B: code 1 reserved; 2 clear up; 3 reverse.
// RULE10 - Fast PWM, A compare at TOP, upper bit set: act at BOTTOM only.
// RULE11 - Phase PWM, A compare at TOP, upper bit set: act at TOP only.
// RULE12 - Either PWM, B compare at TOP, upper bit set: act at TOP.
// RULE13 - Control bits 3 and 2 ignore writes and read zero.
// RULE14 - Two low mode bits plus top mode bit select sequence and TOP.
// RULE15 - Modes 0, 1, 3: fixed TOP, update and overflow as tabled.
// RULE16 - Modes 2, 5, 7 use compare A as TOP; 4 and 6 reserved.
// RULE17 - Compare A as TOP: A match sets flag, counter clears next tick.
// RULE18 - B flag on every match; A flag on every ordinary match.
// RULE19 - BOTTOM is counter value zero.
module t8wc_top (
  input wire logic clock,
  input wire logic rst,
  input wire t8wc_pkg::t8wc_wb_req_t wb_req,
  output t8wc_pkg::t8wc_wb_rsp_t wb_rsp,
  input wire logic timer_tick_enable,
  input wire logic port_a_dat,
  input wire logic port_b_dat,
  output t8wc_pkg::t8wc_pins_t pins,
  output logic irq
);

  // ============================================================
  // Decode helpers
  function automatic t8wc_pkg::t8wc_wave_t wave_of(
    input logic [2:0] mode
  );
    case (mode)
      3'h0, 3'h2: wave_of = t8wc_pkg::T8WC_WAVE_NORMAL; // [RULE15] [RULE16]
      3'h1, 3'h5: wave_of = t8wc_pkg::T8WC_WAVE_PHASE; // [RULE15] [RULE16]
      3'h3, 3'h7: wave_of = t8wc_pkg::T8WC_WAVE_FAST; // [RULE15] [RULE16]
      default: wave_of = t8wc_pkg::T8WC_WAVE_HOLD; // [RULE16]
    endcase
  endfunction : wave_of

  function automatic logic top_from_a(input logic [2:0] mode);
    top_from_a = (mode == 3'h2) || (mode == 3'h5) || (mode == 3'h7);
  endfunction : top_from_a

  function automatic logic hits(
    input logic [7:0] cnt,
    input logic [7:0] val
  );
    hits = (cnt == val);
  endfunction : hits

  // ============================================================
  // Current state and events
  t8wc_pkg::t8wc_state_t s;
  t8wc_pkg::t8wc_state_t n;

  logic [2:0] mode;
  t8wc_pkg::t8wc_wave_t wave;
  logic [7:0] top;
  logic tick;
  logic at_top;
  logic match_a;
  logic match_b;
  logic ovf;
  logic [2:0] ev_set;
  t8wc_pkg::t8wc_chan_ev_t ev_a;
  t8wc_pkg::t8wc_chan_ev_t ev_b;
  logic oc_a_nxt;
  logic oc_b_nxt;
  logic conn_a;
  logic conn_b;
  logic bus_req;
  logic wr_hit;
  logic wr_cnt;

  assign mode = {s.top_bit, s.ctrl_a[1:0]}; // [RULE14]
  assign wave = wave_of(mode);
  assign top = top_from_a(mode) ? s.cmp_a : `T8WC_MAX; // [RULE15] [RULE16]
  // Reserved modes freeze the counter rather than guess a sequence
  assign tick = timer_tick_enable && (wave != t8wc_pkg::T8WC_WAVE_HOLD); // [RULE1]
  assign at_top = tick && hits(s.cnt, top);
  // A counter write removes the match on the following tick
  assign match_a = tick && !s.blocked && hits(s.cnt, s.cmp_a);
  assign match_b = tick && !s.blocked && hits(s.cnt, s.cmp_b);

  always_comb begin
    if (wave == t8wc_pkg::T8WC_WAVE_PHASE) begin
      ovf = tick && hits(s.cnt, `T8WC_BOTTOM); // [RULE15] [RULE19]
    end else if (mode == 3'h7) begin
      ovf = at_top; // [RULE16]
    end else begin
      ovf = tick && hits(s.cnt, `T8WC_MAX); // [RULE15]
    end
  end

  assign ev_set = {match_b, match_a, ovf}; // [RULE17] [RULE18]

  always_comb begin
    ev_a.match = match_a;
    ev_a.up = !s.down || hits(s.cnt, `T8WC_BOTTOM); // [RULE19]
    ev_a.at_bottom = at_top && (wave == t8wc_pkg::T8WC_WAVE_FAST); // [RULE19]
    ev_a.at_top = at_top;
    ev_a.special = s.ctrl_a[`T8WC_COMA_HI] && hits(s.cmp_a, top); // [RULE10] [RULE11]
    ev_b = ev_a;
    ev_b.match = match_b;
    ev_b.special = s.ctrl_a[`T8WC_COMB_HI] && hits(s.cmp_b, top); // [RULE12]
  end

  // ============================================================
  // Compare-output channels
  t8wc_chan u_chan_a (
    .wave(wave),
    .com(s.ctrl_a[`T8WC_COMA_HI:`T8WC_COMA_LO]),
    .is_a(1'b1),
    .top_bit(s.top_bit),
    .ev(ev_a),
    .oc_cur(s.oc_a),
    .oc_nxt(oc_a_nxt),
    .connected(conn_a)
  );

  t8wc_chan u_chan_b (
    .wave(wave),
    .com(s.ctrl_a[`T8WC_COMB_HI:`T8WC_COMB_LO]),
    .is_a(1'b0),
    .top_bit(s.top_bit),
    .ev(ev_b),
    .oc_cur(s.oc_b),
    .oc_nxt(oc_b_nxt),
    .connected(conn_b)
  );

  // ============================================================
  // Bus decode
  assign bus_req = wb_req.cyc && wb_req.stb;
  assign wr_hit = bus_req && wb_req.we && wb_req.sel[0]
                  && (s.bus == t8wc_pkg::T8WC_BUS_IDLE);
  assign wr_cnt = wr_hit && (wb_req.adr == `T8WC_ADR_COUNT);

  // ============================================================
  // Next state
  always_comb begin
    n = s;
    n.rsp.ack = 1'b0;

    // Counter step, one per tick at most
    if (tick) begin // [RULE1]
      n.blocked = 1'b0;
      if (wave == t8wc_pkg::T8WC_WAVE_PHASE) begin
        if (!s.down) begin
          n.down = hits(s.cnt, top);
          n.cnt = hits(s.cnt, top) ? s.cnt - 8'h01 : s.cnt + 8'h01;
        end else begin
          n.down = !hits(s.cnt, `T8WC_BOTTOM); // [RULE19]
          n.cnt = n.down ? s.cnt - 8'h01 : s.cnt + 8'h01;
        end
      end else begin
        n.cnt = hits(s.cnt, top) ? `T8WC_BOTTOM : s.cnt + 8'h01; // [RULE17]
      end
    end

    // Double-buffered compare values
    case (wave)
      t8wc_pkg::T8WC_WAVE_PHASE, t8wc_pkg::T8WC_WAVE_FAST: begin
        if (at_top) begin // [RULE15] [RULE16]
          n.cmp_a = s.cmp_a_buf;
          n.cmp_b = s.cmp_b_buf;
        end
      end
      default: begin
        n.cmp_a = s.cmp_a_buf;
        n.cmp_b = s.cmp_b_buf;
      end
    endcase

    n.oc_a = oc_a_nxt;
    n.oc_b = oc_b_nxt;

    // Bus slave: one ack, then one idle cycle
    case (s.bus)
      t8wc_pkg::T8WC_BUS_IDLE: begin
        if (bus_req) begin
          n.bus = t8wc_pkg::T8WC_BUS_ACK;
          n.rsp.ack = 1'b1;
          case (wb_req.adr)
            `T8WC_ADR_CTRLA: n.rsp.dat = {24'h0, s.ctrl_a & `T8WC_CTRLA_MASK}; // [RULE13]
            `T8WC_ADR_CTRLB: n.rsp.dat = {28'h0, s.top_bit, 3'h0};
            `T8WC_ADR_COUNT: n.rsp.dat = {24'h0, s.cnt};
            `T8WC_ADR_CMPA: n.rsp.dat = {24'h0, s.cmp_a_buf};
            `T8WC_ADR_CMPB: n.rsp.dat = {24'h0, s.cmp_b_buf};
            `T8WC_ADR_STAT: n.rsp.dat = {29'h0, s.status};
            `T8WC_ADR_IEN: n.rsp.dat = {29'h0, s.ien};
            `T8WC_ADR_DIR: n.rsp.dat = {30'h0, s.dir};
            default: n.rsp.dat = 32'h0;
          endcase
        end
      end
      t8wc_pkg::T8WC_BUS_ACK: n.bus = t8wc_pkg::T8WC_BUS_IDLE;
      default: n.bus = t8wc_pkg::T8WC_BUS_IDLE;
    endcase

    // Register writes; software beats a tick on the counter
    n.status = s.status;
    if (wr_hit) begin
      case (wb_req.adr)
        `T8WC_ADR_CTRLA: n.ctrl_a = wb_req.dat[7:0] & `T8WC_CTRLA_MASK; // [RULE13]
        `T8WC_ADR_CTRLB: n.top_bit = wb_req.dat[`T8WC_TOPBIT_POS]; // [RULE14]
        `T8WC_ADR_COUNT: begin
          n.cnt = wb_req.dat[7:0];
          n.blocked = 1'b1;
        end
        `T8WC_ADR_CMPA: n.cmp_a_buf = wb_req.dat[7:0];
        `T8WC_ADR_CMPB: n.cmp_b_buf = wb_req.dat[7:0];
        `T8WC_ADR_CLR: n.status = s.status & ~wb_req.dat[2:0];
        `T8WC_ADR_IEN: n.ien = wb_req.dat[2:0];
        `T8WC_ADR_DIR: n.dir = wb_req.dat[1:0];
        default: n.status = s.status;
      endcase
    end
    // A flag raised in the clear cycle survives
    n.status = n.status | ev_set; // [RULE18]
    n.irq = |(n.status & n.ien);

    // Pin override follows the channel's own ownership
    n.pins.a_o = conn_a ? oc_a_nxt : port_a_dat; // [RULE2]
    n.pins.b_o = conn_b ? oc_b_nxt : port_b_dat; // [RULE2]
    n.pins.a_oe = s.dir[`T8WC_DIR_A]; // [RULE2]
    n.pins.b_oe = s.dir[`T8WC_DIR_B]; // [RULE2]
  end

  // ============================================================
  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.bus <= t8wc_pkg::T8WC_BUS_IDLE;
      s.ctrl_a <= `T8WC_RST_BYTE;
      s.cnt <= `T8WC_RST_BYTE;
      s.status <= `T8WC_RST_FLAGS;
    end else begin
      s <= n;
    end
  end

  assign wb_rsp = s.rsp;
  assign pins = s.pins;
  assign irq = s.irq;

  // ============================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic phase_w;
  logic fast_w;
  logic normal_w;
  assign phase_w = (wave == t8wc_pkg::T8WC_WAVE_PHASE);
  assign fast_w = (wave == t8wc_pkg::T8WC_WAVE_FAST);
  assign normal_w = (wave == t8wc_pkg::T8WC_WAVE_NORMAL);

  sequence s_bus_req;
    bus_req && (s.bus == t8wc_pkg::T8WC_BUS_IDLE);
  endsequence

  sequence s_phase_peak;
    phase_w && at_top && !s.down && !wr_cnt;
  endsequence

  a_count_gated: assert property ( // [RULE1]
    !timer_tick_enable && !wr_cnt |=> $stable(s.cnt))
    else $error("counter moved without a tick");

  a_pin_owner: assert property ( // [RULE2]
    conn_a && s.dir[0] |=> pins.a_oe && (pins.a_o == s.oc_a))
    else $error("pin A not driven by compare output");

  a_normal_toggle: assert property ( // [RULE3]
    normal_w && s.ctrl_a[7:6] == 2'b01 && match_a |=> s.oc_a != $past(s.oc_a))
    else $error("channel A did not toggle");

  a_normal_clear_b: assert property ( // [RULE4]
    normal_w && s.ctrl_a[5:4] == 2'b10 && match_b |=> !s.oc_b)
    else $error("channel B not cleared on match");

  a_fast_bottom_set: assert property ( // [RULE5]
    fast_w && s.ctrl_a[7:6] == 2'b10 && ev_a.at_bottom |=> s.oc_a)
    else $error("channel A not set at bottom");

  a_phase_up_clear: assert property ( // [RULE8]
    phase_w && s.ctrl_a[7:6] == 2'b10 && match_a && ev_a.up && !ev_a.special
    |=> !s.oc_a)
    else $error("channel A not cleared on up match");

  a_phase_down_set_b: assert property ( // [RULE9]
    phase_w && s.ctrl_a[5:4] == 2'b10 && match_b && !ev_b.up && !ev_b.special
    |=> s.oc_b)
    else $error("channel B not set on down match");

  a_phase_turn: assert property ( // [RULE15]
    s_phase_peak |=> s.down && (s.cnt == $past(s.cnt) - 8'h01))
    else $error("phase mode did not turn at top");

  a_ctrl_reserved: assert property ( // [RULE13]
    s_bus_req and (!wb_req.we && wb_req.adr == `T8WC_ADR_CTRLA)
    |=> wb_rsp.ack && wb_rsp.dat[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");

  a_match_clears: assert property ( // [RULE17]
    top_from_a(mode) && !phase_w && match_a && !wr_cnt
    |=> s.cnt == `T8WC_BOTTOM && s.status[1])
    else $error("compare A at top did not clear counter");

  a_flag_b: assert property ( // [RULE18]
    match_b |=> s.status[`T8WC_FLAG_MB] ##1 (irq || !s.ien[2]))
    else $error("compare B flag or interrupt missing");

  a_bus_ack: assert property (
    s_bus_req |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("bus ack not a single cycle");

endmodule : t8wc_top

// ==== verif/t8wc_pin_model.sv ====
/*
  Pad model for the two compare pins: port pin with a pull-up.
  Assumes the pin carrier of the timer top; the bench judges the pads.
*/
`timescale 1ns/1ps

module t8wc_pin_model (
  input wire t8wc_pkg::t8wc_pins_t pins,
  output logic pad_a,
  output logic pad_b
);
  // ============================================================
  // Pads
  // A released pad rises to the pull-up, never holds the old level
  assign pad_a = pins.a_oe ? pins.a_o : 1'h1;
  assign pad_b = pins.b_oe ? pins.b_o : 1'h1;
endmodule : t8wc_pin_model

// ==== verif/t8wc_tb_top.sv ====
/*
  Self-checking bench of the timer waveform block: Wishbone tasks,
  tick bursts and pad checks. Assumes a 125 MHz clock and the pin model.
*/
`timescale 1ns/1ps
`include "t8wc_regs.svh"

module t8wc_tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  t8wc_pkg::t8wc_wb_req_t wb_req = '0;
  t8wc_pkg::t8wc_wb_rsp_t wb_rsp;
  logic tick = 1'h0;
  logic port_a = 1'h0;
  logic port_b = 1'h0;
  t8wc_pkg::t8wc_pins_t pins;
  logic irq;
  logic pad_a;
  logic pad_b;
  logic [31:0] rd;
  int err_count = 0;
  int total_checks = 0;

  always #4 clock = ~clock;

  t8wc_top t8wc_top_inst (.clock(clock), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .timer_tick_enable(tick), .port_a_dat(port_a), .port_b_dat(port_b),
    .pins(pins), .irq(irq));
  t8wc_pin_model t8wc_pin_model_inst (.pins(pins), .pad_a(pad_a), .pad_b(pad_b));

  // ============================================================
  // Compare and bus tasks
  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte

  // Ack and read data are sampled at the rising edge; release follows at that edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: {24'h0, wd}};
    @(posedge clock);
    while (wb_rsp.ack !== 1'h1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) chk_bit(1'h0, 1'h1, "no ack");
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    wb(1'h1, adr, wd);
  endtask : wr

  task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp, input string what);
    wb(1'h0, adr, 8'h00);
    chk_byte(rd[7:0], exp, what);
  endtask : rdchk

  task automatic settle;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask : settle

  // Tick held for n edges, then the pins get time to follow
  task automatic ticks(input int n);
    @(posedge clock);
    tick <= 1'h1;
    repeat (n) @(posedge clock);
    tick <= 1'h0;
    settle;
  endtask : ticks

  task automatic pads(input logic ea, input logic eb);
    chk_bit(pad_a, ea, "pad a");
    chk_bit(pad_b, eb, "pad b");
  endtask : pads

  // ============================================================
  // Scenarios
  task automatic t_regs;
    chk_bit(irq, 1'h0, "irq after reset");
    chk_bit(pins.a_oe, 1'h0, "pin a enable after reset");
    rdchk(`T8WC_ADR_CTRLA, 8'h00, "ctrl reset");
    wr(`T8WC_ADR_CTRLA, 8'hFF);
    rdchk(`T8WC_ADR_CTRLA, 8'hF3, "ctrl reserved bits");
    wr(8'h7C, 8'hFF);
    rdchk(8'h7C, 8'h00, "unmapped read");
    wr(`T8WC_ADR_CTRLA, 8'h00);
  endtask : t_regs

  // Set, clear, toggle, toggle on both channels in normal mode
  task automatic t_nonpwm;
    logic [1:0] codes [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
    logic lvl [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
    wr(`T8WC_ADR_DIR, 8'h03);
    wr(`T8WC_ADR_CMPA, 8'h40);
    wr(`T8WC_ADR_CMPB, 8'h40);
    settle;
    pads(1'h0, 1'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`T8WC_ADR_CTRLA, {codes[i], codes[i], 4'h0});
      wr(`T8WC_ADR_COUNT, 8'h3E);
      ticks(3);
      pads(lvl[i], lvl[i]);
    end
    rdchk(`T8WC_ADR_STAT, 8'h06, "match flags");
    chk_bit(irq, 1'h0, "irq masked");
    port_a <= 1'h1;
    wr(`T8WC_ADR_DIR, 8'h00);
    settle;
    pads(1'h1, 1'h1);
    wr(`T8WC_ADR_DIR, 8'h03);
  endtask : t_nonpwm

  task automatic t_irq;
    wr(`T8WC_ADR_CLR, 8'h07);
    wr(`T8WC_ADR_COUNT, 8'hFE);
    ticks(2);
    rdchk(`T8WC_ADR_STAT, 8'h01, "overflow at max");
    chk_bit(irq, 1'h0, "irq masked");
    wr(`T8WC_ADR_IEN, 8'h01);
    settle;
    chk_bit(irq, 1'h1, "irq enabled");
    wr(`T8WC_ADR_CLR, 8'h01);
    settle;
    chk_bit(irq, 1'h0, "irq cleared");
    rdchk(`T8WC_ADR_STAT, 8'h00, "status cleared");
  endtask : t_irq

  task automatic t_ctc;
    wr(`T8WC_ADR_CMPA, 8'h05);
    wr(`T8WC_ADR_CTRLA, 8'h02);
    wr(`T8WC_ADR_COUNT, 8'h03);
    ticks(3);
    rdchk(`T8WC_ADR_COUNT, 8'h00, "cleared on match");
    rdchk(`T8WC_ADR_STAT, 8'h02, "a flag at top");
  endtask : t_ctc

  // Fast PWM: A non-inverting, B inverting, both compares at 0x10
  task automatic t_fast;
    wr(`T8WC_ADR_CTRLA, 8'h00);
    wr(`T8WC_ADR_CMPA, 8'h10);
    wr(`T8WC_ADR_CMPB, 8'h10);
    wr(`T8WC_ADR_CLR, 8'h07);
    wr(`T8WC_ADR_CTRLA, 8'hB3);
    wr(`T8WC_ADR_COUNT, 8'hFD);
    ticks(4);
    pads(1'h1, 1'h0);
    wr(`T8WC_ADR_COUNT, 8'h0E);
    ticks(3);
    pads(1'h0, 1'h1);
    rdchk(`T8WC_ADR_STAT, 8'h07, "fast flags");
    port_b <= 1'h0;
    wr(`T8WC_ADR_CTRLA, 8'h53);
    settle;
    pads(1'h1, 1'h0);
  endtask : t_fast

  // Phase correct: up match then the down match after turning at 0xFF
  task automatic t_phase;
    wr(`T8WC_ADR_CTRLA, 8'hB1);
    wr(`T8WC_ADR_COUNT, 8'h0E);
    ticks(3);
    pads(1'h0, 1'h1);
    ticks(470);
    pads(1'h0, 1'h1);
    ticks(20);
    pads(1'h1, 1'h0);
  endtask : t_phase

  // Compare A as TOP in fast PWM with A toggling, then a reserved mode freezes
  task automatic t_top;
    wr(`T8WC_ADR_CTRLB, 8'h08);
    wr(`T8WC_ADR_CTRLA, 8'h43);
    wr(`T8WC_ADR_CLR, 8'h07);
    wr(`T8WC_ADR_COUNT, 8'h0E);
    ticks(3);
    pads(1'h0, 1'h0);
    rdchk(`T8WC_ADR_COUNT, 8'h00, "cleared at compare a top");
    rdchk(`T8WC_ADR_STAT, 8'h07, "flags at compare a top");
    wr(`T8WC_ADR_CTRLA, 8'h42);
    ticks(2);
    rdchk(`T8WC_ADR_COUNT, 8'h00, "reserved mode frozen");
  endtask : t_top

  // ============================================================
  // Run control
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    t_regs;
    t_nonpwm;
    t_irq;
    t_ctc;
    t_fast;
    t_phase;
    t_top;
    end_of_test;
  end

  // The tests need about 750 cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule : t8wc_tb_top
